// >>> src/rtcas_top.sv
// rtc control: trim, rate adjust, count-error flag, shadow and sub-second
// assumes apb master on clk; count error arrives on an asynchronous pin
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - a detected count error sets the count-error flag
// R2 - the count-error flag stays set until software writes zero to it
// R3 - software keeps coarse rate adjust between 0x0FFBF and 0x10040
// R4 - coarse and fine fields join into one 19-bit value, coarse on top
// R5 - setting read freeze holds the time shadow constant, except for time writes during a write freeze
// R6 - read freeze bit reads back shadow status: 0 current, 1 frozen
// R7 - read-only 8-bit sub-second counter, one count per 1/128 second
// R8 - 7-bit read-write oscillator trim, reset value 0x40
// R9 - with auto compensation on, each temperature result rewrites adjust
// R10 - write freeze clear loads shadow next 1 kHz tick; reads set until done
// R11 - live counter keeps running while shadow is read-frozen
module rtcas_top #(
  parameter int SUB_DIV = rtcas_pkg::SUB_DIV,
  parameter int RTC_DIV = rtcas_pkg::RTC_DIV
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic countErrPin,
  input wire logic tempDone,
  input wire rtcas_pkg::rtcas_adj_s tempAdj,
  output rtcas_pkg::rtcas_adj_s rateAdj,
  output logic [6:0] oscTrim,
  output logic irq
);
  // ==========================================================
  // reset release
  logic [1:0] rstPipe;
  logic rstN;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // ==========================================================
  // state
  logic failFlag;
  logic readFreeze;
  logic compEn;
  logic errS;
  logic errPrev;
  logic [rtcas_pkg::IRQ_W-1:0] irqStat;
  logic [rtcas_pkg::IRQ_W-1:0] irqMask;
  rtcas_pkg::rtcas_time_s live;
  rtcas_pkg::rtcas_time_s shadow;
  rtcas_pkg::rtcas_wf_e wfState;
  rtcas_pkg::rtcas_wf_e next_wfState;
  logic subTick;
  logic rtcTick;

  rtcas_sync #(.W(1)) uErrSync (
    .clk(clk),
    .rstN(rstN),
    .d(countErrPin),
    .q(errS)
  );
  rtcas_tick #(.DIV(SUB_DIV)) uSubTick (
    .clk(clk),
    .rstN(rstN),
    .ce(ce),
    .tick(subTick)
  );
  rtcas_tick #(.DIV(RTC_DIV)) uRtcTick (
    .clk(clk),
    .rstN(rstN),
    .ce(ce),
    .tick(rtcTick)
  );

  // ==========================================================
  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire commit = access & ce;
  wire wr = commit & pwrite;
  wire hitTrim = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_TRIM);
  wire hitCtrl = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_CTRL);
  wire hitSub = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_SUBSEC);
  wire hitHi = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_ADJ_HI);
  wire hitMid = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_ADJ_MID);
  wire hitLo = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_ADJ_LO);
  wire hitComp = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_TCOMP);
  wire hitStat = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_IRQ_STAT);
  wire hitMask = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_IRQ_MASK);
  wire hitTime = paddr == rtcas_pkg::regAddr(rtcas_pkg::IDX_TIME);
  wire mapped = |{hitTrim, hitCtrl, hitSub, hitHi, hitMid, hitLo, hitComp,
                  hitStat, hitMask, hitTime};
  // a frozen block cannot take a write, so the master is stalled instead
  assign pready = ce;
  assign pslverr = access & ~mapped;
  wire wrCtrl = wr & hitCtrl;
  wire wfSetReq = wrCtrl & pwdata[rtcas_pkg::CTL_WF_BIT];
  wire wfClrReq = wrCtrl & ~pwdata[rtcas_pkg::CTL_WF_BIT];

  // ==========================================================
  // read mux; sampled in the setup cycle, shown in the access cycle
  wire [7:0] ctrlRd = {wfState != rtcas_pkg::WF_IDLE, readFreeze, 1'b0,
                       failFlag, 4'h0};
  wire [31:0] rdMux =
    hitTrim ? {25'h0, oscTrim} :
    hitCtrl ? {24'h0, ctrlRd} :                             // [R6] [R10]
    hitSub ? {24'h0, shadow.sub} :                          // [R7]
    hitHi ? {29'h0, rateAdj.p[16:14]} :
    hitMid ? {24'h0, rateAdj.p[13:6]} :
    hitLo ? {24'h0, rateAdj.p[5:0], rateAdj.q} :
    hitComp ? {26'h0, compEn, 5'h00} :
    hitStat ? {29'h0, irqStat} :
    hitMask ? {29'h0, irqMask} :
    hitTime ? shadow.sec : 32'h0000_0000;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prdata <= 32'h0000_0000;
    end else if (ce && setup) begin
      prdata <= rdMux;
    end
  end

  // ==========================================================
  // trim and compensation enable
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      oscTrim <= rtcas_pkg::TRIM_RST;                       // [R8]
      compEn <= 1'b0;
    end else begin
      if (wr && hitTrim) oscTrim <= pwdata[6:0];            // [R8]
      if (wr && hitComp) compEn <= pwdata[rtcas_pkg::TCOMP_EN_BIT];
    end
  end

  // ==========================================================
  // rate adjust; a temperature result wins over a same-cycle write
  wire tempLoad = ce & tempDone & compEn;                   // [R9]
  rtcas_pkg::rtcas_adj_s next_rateAdj;
  assign next_rateAdj.p[16:14] = (wr && hitHi) ? pwdata[2:0]
                                               : rateAdj.p[16:14];
  assign next_rateAdj.p[13:6] = (wr && hitMid) ? pwdata[7:0]
                                               : rateAdj.p[13:6];
  assign next_rateAdj.p[5:0] = (wr && hitLo) ? pwdata[7:2]
                                             : rateAdj.p[5:0];
  assign next_rateAdj.q = (wr && hitLo) ? pwdata[1:0] : rateAdj.q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rateAdj <= '{p: rtcas_pkg::P_RST, q: rtcas_pkg::Q_RST};
    end else if (tempLoad) begin
      rateAdj <= tempAdj;                                   // [R9]
    end else begin
      rateAdj <= next_rateAdj;                              // [R4]
    end
  end

  // ==========================================================
  // count error flag; a new error beats a same-cycle clear
  wire errEvt = errS & ~errPrev;
  wire failClr = wrCtrl & ~pwdata[rtcas_pkg::CTL_FAIL_BIT];
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      errPrev <= 1'b0;
      failFlag <= 1'b0;
    end else if (ce) begin
      errPrev <= errS;
      if (errEvt) failFlag <= 1'b1;                         // [R1]
      else if (failClr) failFlag <= 1'b0;                   // [R2]
    end
  end

  // ==========================================================
  // live counter and shadow
  wire secTick = subTick & (live.sub == rtcas_pkg::SUB_LAST);
  wire loadLive = (wfState == rtcas_pkg::WF_LOAD) & rtcTick;
  rtcas_pkg::rtcas_time_s next_live;
  assign next_live.sub = secTick ? 8'h00 : live.sub + 8'h01; // [R7]
  assign next_live.sec = live.sec + {31'h0, secTick};
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      live <= '0;
    end else if (loadLive) begin
      live <= shadow;                                       // [R10]
    end else if (subTick) begin
      live <= next_live;                                    // [R11]
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      readFreeze <= 1'b0;
    end else if (wrCtrl) begin
      readFreeze <= pwdata[rtcas_pkg::CTL_RF_BIT];          // [R5]
    end
  end
  // the shadow only tracks while neither freeze holds it
  wire wfIdle = wfState == rtcas_pkg::WF_IDLE;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      shadow <= '0;
    end else if (ce) begin
      if (!wfIdle && wr && hitTime) shadow.sec <= pwdata;
      else if (wfIdle && !readFreeze) shadow <= live;       // [R5] [R11]
    end
  end

  // ==========================================================
  // write freeze sequence
  always_comb begin
    next_wfState = wfState;
    unique case (wfState)
      rtcas_pkg::WF_IDLE: begin
        if (wfSetReq) next_wfState = rtcas_pkg::WF_HOLD;
      end
      rtcas_pkg::WF_HOLD: begin
        if (wfClrReq) next_wfState = rtcas_pkg::WF_LOAD;    // [R10]
      end
      rtcas_pkg::WF_LOAD: begin
        if (rtcTick) next_wfState = rtcas_pkg::WF_IDLE;     // [R10]
      end
      default: next_wfState = rtcas_pkg::WF_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wfState <= rtcas_pkg::WF_IDLE;
    end else if (ce) begin
      wfState <= next_wfState;
    end
  end

  // ==========================================================
  // interrupts: sticky, write one to clear, an event wins over clear
  wire [rtcas_pkg::IRQ_W-1:0] irqEvt = {secTick, tempLoad, errEvt & ce};
  wire [rtcas_pkg::IRQ_W-1:0] irqClr =
    (wr && hitStat) ? pwdata[rtcas_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqStat <= '0;
      irqMask <= '0;
    end else begin
      irqStat <= (irqStat & ~irqClr) | irqEvt;
      if (wr && hitMask) irqMask <= pwdata[rtcas_pkg::IRQ_W-1:0];
    end
  end
  assign irq = |(irqStat & irqMask);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  fail_set_a: assert property ( // [R1]
    ce && errEvt |=> failFlag)
    else $error("count error did not set flag");
  fail_hold_a: assert property ( // [R2]
    failFlag && !(ce && failClr) |=> failFlag)
    else $error("count error flag dropped without a zero write");
  fail_clear_a: assert property ( // [R2]
    ce && failClr && !errEvt |=> !failFlag)
    else $error("zero write did not clear count error flag");
  adj_join_a: assert property ( // [R4]
    wr && hitLo && !tempLoad |=> rateAdj[7:0] == $past(pwdata[7:0]))
    else $error("fine field not in low bits of adjust value");
  shadow_hold_a: assert property ( // [R5]
    readFreeze && wfIdle ##1 readFreeze |-> $stable(shadow))
    else $error("shadow moved while read-frozen");
  freeze_read_a: assert property ( // [R6]
    ce && setup && hitCtrl |=> prdata[rtcas_pkg::CTL_RF_BIT]
                               == $past(readFreeze))
    else $error("read freeze readback wrong");
  sub_step_a: assert property ( // [R7]
    subTick && !loadLive |=> live.sub == (($past(live.sub) == 8'h7F)
                              ? 8'h00 : $past(live.sub) + 8'h01))
    else $error("sub-second counter stepped wrongly");
  sub_range_a: assert property ( // [R7]
    live.sub <= rtcas_pkg::SUB_LAST)
    else $error("sub-second counter out of range");
  trim_keep_a: assert property ( // [R8]
    !(wr && hitTrim) |=> $stable(oscTrim))
    else $error("trim changed without a write");
  comp_load_a: assert property ( // [R9]
    tempLoad |=> rateAdj == $past(tempAdj))
    else $error("temperature result not loaded into adjust");
  wf_load_a: assert property ( // [R10]
    loadLive |=> live == $past(shadow) && wfIdle)
    else $error("write freeze release did not load counter");
  wf_report_a: assert property ( // [R10]
    wfState == rtcas_pkg::WF_LOAD |-> ctrlRd[rtcas_pkg::CTL_WF_BIT])
    else $error("write freeze read as clear before load");
  live_runs_a: assert property ( // [R11]
    readFreeze && secTick && !loadLive |=> live.sec
                                          == $past(live.sec) + 32'h1)
    else $error("live counter stalled under read freeze");

  err_seen_c: cover property (errEvt && failFlag);
  wf_done_c: cover property (loadLive);
  frozen_sec_c: cover property (readFreeze && secTick);
  comp_load_c: cover property (tempLoad);
endmodule

// >>> src/rtcas_pkg.sv
// rtc adjust and shadow control: shared constants, types and states
// assumes a 25 MHz system clock and a 32-bit apb register bus
package rtcas_pkg;
  // ==========================================================
  // register map (index; byte address is four times it)
  localparam logic [15:0] IDX_TRIM = 16'h2504;
  localparam logic [15:0] IDX_CTRL = 16'h2890;
  localparam logic [15:0] IDX_SUBSEC = 16'h2892;
  localparam logic [15:0] IDX_ADJ_HI = 16'h289B;
  localparam logic [15:0] IDX_ADJ_MID = 16'h289C;
  localparam logic [15:0] IDX_ADJ_LO = 16'h289D;
  localparam logic [15:0] IDX_TCOMP = 16'h28A0;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h28F0;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h28F1;
  localparam logic [15:0] IDX_TIME = 16'h28F2;
  // ==========================================================
  // field positions and reset values
  localparam int CTL_WF_BIT = 7;
  localparam int CTL_RF_BIT = 6;
  localparam int CTL_FAIL_BIT = 4;
  localparam int TCOMP_EN_BIT = 5;
  localparam int TRIM_W = 7;
  localparam logic [6:0] TRIM_RST = 7'h40;
  localparam logic [16:0] P_RST = 17'h10000;
  localparam logic [1:0] Q_RST = 2'h0;
  localparam logic [7:0] SUB_LAST = 8'h7F;
  localparam int IRQ_FAIL = 0;
  localparam int IRQ_TCOMP = 1;
  localparam int IRQ_SEC = 2;
  localparam int IRQ_W = 3;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SUB_PERIOD_NS = 7_812_500;
  localparam int RTC_PERIOD_NS = 1_000_000;
  localparam int SUB_DIV = SUB_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RTC_DIV = RTC_PERIOD_NS / CLK_PERIOD_NS;
  // ==========================================================
  // types
  typedef struct packed {
    logic [16:0] p;
    logic [1:0] q;
  } rtcas_adj_s;
  typedef struct packed {
    logic [31:0] sec;
    logic [7:0] sub;
  } rtcas_time_s;
  typedef enum logic [2:0] {
    WF_IDLE = 3'b001,
    WF_HOLD = 3'b010,
    WF_LOAD = 3'b100
  } rtcas_wf_e;
  function automatic logic [15:0] regAddr(input logic [15:0] idx);
    regAddr = {idx[13:0], 2'b00};
  endfunction
endpackage

// >>> src/rtcas_sync.sv
// two-flop synchroniser for levels from outside the clock domain
// assumes a reset already released synchronously to clk
`timescale 1ns/1ps
module rtcas_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // ==========================================================
  // only the second stage is visible outside
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> src/rtcas_tick.sv
// free-running divider giving a one-cycle tick every DIV enabled clocks
// assumes ce gates all counting
`timescale 1ns/1ps
module rtcas_tick #(
  parameter int DIV = 25000
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic ce,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt;
  wire atEnd = (cnt == CW'(DIV - 1));
  assign tick = ce & atEnd;
  // ==========================================================
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= atEnd ? '0 : cnt + CW'(1);
    end
  end
endmodule

// >>> dv/rtc_adjust_and_shadow_control_test.sv
// self-checking testbench for the rtc adjust and shadow control block
// assumes rtcas_top with shortened dividers and a 25 MHz apb clock
`timescale 1ns/1ps
module rtc_adjust_and_shadow_control_test;
  // ==========================================================
  // signals and bench state
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic countErrPin = 1'b0;
  logic tempDone = 1'b0;
  rtcas_pkg::rtcas_adj_s tempAdj = '0;
  rtcas_pkg::rtcas_adj_s rateAdj;
  logic [6:0] oscTrim;
  logic irq;
  logic [32:0] expQ[$];
  logic [31:0] seed = 32'hF207D3CD;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  // short dividers keep the run small; expectations use these values
  rtcas_top #(.SUB_DIV(4), .RTC_DIV(3)) dut_u (
    .clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .countErrPin(countErrPin),
    .tempDone(tempDone), .tempAdj(tempAdj), .rateAdj(rateAdj),
    .oscTrim(oscTrim), .irq(irq)
  );

  // ==========================================================
  // helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // apb master: request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
                    input logic err = 1'b0);
    expQ.push_back({err, exp});
    apb(1'b0, idx, 32'h0);
  endtask

  task automatic rdv(input logic [15:0] idx, output logic [31:0] v);
    apb(1'b0, idx, 32'h0);
    v = prdata;
  endtask

  task automatic pulseTemp(input rtcas_pkg::rtcas_adj_s a);
    @(posedge clk);
    tempAdj <= a;
    tempDone <= 1'b1;
    @(posedge clk);
    tempDone <= 1'b0;
    @(negedge clk);
  endtask

  // ==========================================================
  // read monitor: oldest note against each completed read while a note is queued
  always @(posedge clk) begin
    logic [32:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk(prdata, e[31:0]);
      chk({31'h0, pslverr}, {31'h0, e[32]});
    end
  end

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] v1;
    logic [31:0] v2;
    logic [16:0] p;
    logic [1:0] q;
    logic [6:0] t;
    rtcas_pkg::rtcas_adj_s a;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({25'h0, oscTrim}, 32'h40);
    chk({13'h0, rateAdj}, 32'h40000);
    // a frozen block must stall the bus
    ce <= 1'b0;
    @(negedge clk);
    chk({31'h0, pready}, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    rd(rtcas_pkg::IDX_TRIM, 32'h40);
    rd(rtcas_pkg::IDX_CTRL, 32'h0);
    rd(rtcas_pkg::IDX_ADJ_HI, 32'h4);
    rd(rtcas_pkg::IDX_ADJ_MID, 32'h0);
    rd(rtcas_pkg::IDX_ADJ_LO, 32'h0);
    rd(16'h2000, 32'h0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      v1 = rnd();
      t = v1[6:0];
      apb(1'b1, rtcas_pkg::IDX_TRIM, v1);
      rd(rtcas_pkg::IDX_TRIM, {25'h0, t});
      chk({25'h0, oscTrim}, {25'h0, t});
      // software keeps the coarse value inside its legal window
      p = 17'h0FFBF + 17'(rnd() % 130);
      q = 2'(rnd());
      apb(1'b1, rtcas_pkg::IDX_ADJ_HI, {29'h0, p[16:14]});
      apb(1'b1, rtcas_pkg::IDX_ADJ_MID, {24'h0, p[13:6]});
      apb(1'b1, rtcas_pkg::IDX_ADJ_LO, {24'h0, p[5:0], q});
      @(negedge clk);
      chk({13'h0, rateAdj}, {13'h0, p, q});
      rd(rtcas_pkg::IDX_ADJ_LO, {24'h0, p[5:0], q});
    end
    // count error, seen only once the mask lets it through
    countErrPin <= 1'b1;
    repeat (6) @(posedge clk);
    countErrPin <= 1'b0;
    rd(rtcas_pkg::IDX_CTRL, 32'h10);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, rtcas_pkg::IDX_IRQ_MASK, 32'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, rtcas_pkg::IDX_CTRL, 32'h10);
    rd(rtcas_pkg::IDX_CTRL, 32'h10);
    apb(1'b1, rtcas_pkg::IDX_CTRL, 32'h0);
    rd(rtcas_pkg::IDX_CTRL, 32'h0);
    apb(1'b1, rtcas_pkg::IDX_IRQ_STAT, 32'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    // read freeze: shadow stands still, then tracks the live count
    apb(1'b1, rtcas_pkg::IDX_CTRL, 32'h40);
    rd(rtcas_pkg::IDX_CTRL, 32'h40);
    rdv(rtcas_pkg::IDX_SUBSEC, v1);
    rdv(rtcas_pkg::IDX_TIME, v2);
    // long enough for a whole second to pass in the live counter
    repeat (600) @(posedge clk);
    rd(rtcas_pkg::IDX_SUBSEC, v1);
    rd(rtcas_pkg::IDX_TIME, v2);
    apb(1'b1, rtcas_pkg::IDX_CTRL, 32'h0);
    rd(rtcas_pkg::IDX_CTRL, 32'h0);
    rdv(rtcas_pkg::IDX_SUBSEC, v1);
    repeat (8) @(posedge clk);
    rdv(rtcas_pkg::IDX_SUBSEC, v2);
    // 11 cycles apart at 4 cycles a count: two or three counts on
    v2 = (v2 - v1) & 32'h7F;
    chk({31'h0, v2 == 2 || v2 == 3}, 32'h1);
    // temperature results only load while compensation is on
    a = 19'(rnd());
    pulseTemp(a);
    chk({13'h0, rateAdj}, {13'h0, p, q});
    apb(1'b1, rtcas_pkg::IDX_TCOMP, 32'h20);
    rd(rtcas_pkg::IDX_TCOMP, 32'h20);
    pulseTemp(a);
    chk({13'h0, rateAdj}, {13'h0, a});
    rd(rtcas_pkg::IDX_ADJ_MID, {24'h0, a.p[13:6]});
    // second tick seen while frozen, count error cleared earlier
    rd(rtcas_pkg::IDX_IRQ_STAT, 32'h6);
    // write freeze: shadow takes a new time and loads it on a tick
    apb(1'b1, rtcas_pkg::IDX_CTRL, 32'h80);
    rd(rtcas_pkg::IDX_CTRL, 32'h80);
    apb(1'b1, rtcas_pkg::IDX_TIME, 32'h1234);
    rd(rtcas_pkg::IDX_TIME, 32'h1234);
    apb(1'b1, rtcas_pkg::IDX_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    rd(rtcas_pkg::IDX_CTRL, 32'h0);
    apb(1'b1, rtcas_pkg::IDX_TIME, 32'hFFFF);
    rdv(rtcas_pkg::IDX_TIME, v1);
    chk({31'h0, (v1 - 32'h1234) < 2}, 32'h1);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
